// ---- rtl/ccpr_fifo.sv ----
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------------
// Small synchronous FIFO with valid and ready on both sides.
// ----------------------------------------------------------------------------
module ccpr_fifo #(
    parameter int W = 19,
    parameter int DEPTH = 8
) (
    // Clock, reset and enable.
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    // Filling side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Draining side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    import ccpr_pkg::*;

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // Storage words.
    logic [W-1:0] mem [0:DEPTH-1];
    // Write and read pointers.
    logic [AW-1:0] wr_ptr_q, rd_ptr_q;
    // Number of stored words.
    logic [AW:0] count_q;
    // Registered non-empty flag.
    logic valid_q;
    logic push, pop;
    logic [AW:0] count_d;

    // Full refuses pushes so back-pressure reaches the source.
    assign in_ready = (count_q != (AW+1)'(DEPTH));
    assign push = in_valid && in_ready && ce;
    assign pop = valid_q && out_ready && ce;
    assign out_valid = valid_q;
    assign out_data = mem[rd_ptr_q];

    // Next occupancy.
    always_comb begin
        count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Pointers and occupancy.
    always_ff @(posedge mclk) begin
        if (rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            valid_q <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + AW'(1);
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + AW'(1);
            end
            count_q <= count_d;
            valid_q <= (count_d != '0);
        end
    end

    // Data storage, never reset.
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data;
        end
    end

endmodule // ccpr_fifo

`default_nettype wire

// ---- rtl/ccpr_pkg.sv ----
// ----------------------------------------------------------------------------
// Shared constants and carrier types of the calorimeter charge readout.
// ----------------------------------------------------------------------------
package ccpr_pkg;

    // ------------------------------------------------------------------------
    // Timing.
    // ------------------------------------------------------------------------
    // Clock period of mclk in nanoseconds.
    localparam int CLK_NS = 50;
    // Beam crossing interval in nanoseconds.
    localparam int XING_NS = 132;
    // Cycles per crossing, rounded up so an interval never runs short.
    localparam int XING_CYC = (XING_NS + CLK_NS - 1) / CLK_NS;

    // ------------------------------------------------------------------------
    // Integrator and conversion widths.
    // ------------------------------------------------------------------------
    // Capacitor banks in the integrator pipeline.
    localparam int N_BANK = 4;
    // Ranges, one capacitor each, per bank.
    localparam int N_RANGE = 8;
    // Bank tag width.
    localparam int BANK_W = 2;
    // Range exponent width.
    localparam int RANGE_W = 3;
    // Converter mantissa width.
    localparam int ADC_W = 10;
    // Raw word width: bank tag, range and mantissa.
    localparam int RAW_W = BANK_W + RANGE_W + ADC_W;
    // Linearised magnitude width without the range flag.
    localparam int MAG_W = 15;
    // Linearised word width.
    localparam int LIN_W = MAG_W + 1;
    // Transverse energy word sent to the trigger.
    localparam int ET_W = 10;

    // ------------------------------------------------------------------------
    // Buffering.
    // ------------------------------------------------------------------------
    // Crossings held while the first-level decision is pending.
    localparam int L1_DEPTH = 42;
    // Second-level event buffers.
    localparam int L2_NBUF = 4;
    // Readout FIFO depth in words.
    localparam int FIFO_DEPTH = 8;

    // ------------------------------------------------------------------------
    // Carrier types.
    // ------------------------------------------------------------------------
    // Raw floating-point word of one channel for one crossing.
    typedef struct packed {
        logic [BANK_W-1:0] bank;
        logic [RANGE_W-1:0] range;
        logic [ADC_W-1:0] mant;
    } ccpr_raw_t;

    // Linearised word returned by the lookup memory.
    typedef struct packed {
        logic hi_range;
        logic [MAG_W-1:0] mag;
    } ccpr_lin_t;

    // Word handed to the bus readout controller.
    typedef struct packed {
        logic last;
        logic [1:0] buf_id;
        ccpr_lin_t data;
    } ccpr_rd_t;

    // Readout sequencer states, one-hot.
    typedef enum logic [1:0] {
        RD_IDLE = 2'h1,
        RD_SEND = 2'h2
    } ccpr_rd_state_t;

endpackage

// ---- rtl/ccpr_readout.sv ----
`timescale 1ns/100ps
`default_nettype none

module ccpr_readout #(
    parameter int NCH = 4,
    parameter int ET_AW = 12,
    parameter int PIPE_DEPTH = ccpr_pkg::L1_DEPTH,
    parameter int FDEPTH = ccpr_pkg::FIFO_DEPTH
) (
    // Clock, reset and enable.
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    // Comparator and converter pins, per channel.
    input wire logic [NCH*ccpr_pkg::N_RANGE-1:0] cmp_hit_pin,
    input wire logic [NCH*ccpr_pkg::ADC_W-1:0] adc_pin,
    // Integrator bank steering.
    output logic [ccpr_pkg::BANK_W-1:0] int_bank_q,
    output logic [ccpr_pkg::BANK_W-1:0] cmp_bank_q,
    output logic [ccpr_pkg::BANK_W-1:0] mux_bank_q,
    output logic [ccpr_pkg::BANK_W-1:0] rst_bank_q,
    output logic [NCH*ccpr_pkg::RANGE_W-1:0] mux_range_q,
    // Calibration load of the lookup memories.
    input wire logic cal_we,
    input wire logic cal_et,
    input wire logic [7:0] cal_ch,
    input wire logic [ccpr_pkg::RAW_W-1:0] cal_addr,
    input wire logic [ccpr_pkg::LIN_W-1:0] cal_data,
    // First-level trigger.
    output logic [ccpr_pkg::ET_W-1:0] et_q,
    output logic et_valid_q,
    input wire logic l1_accept,
    input wire logic l1_reject,
    output logic l1_overflow_q,
    // Second-level decision.
    input wire logic l2_accept,
    input wire logic l2_reject,
    input wire logic [1:0] l2_buf,
    output logic [ccpr_pkg::L2_NBUF-1:0] l2_full_q,
    // Readout stream.
    output logic rd_valid,
    input wire logic rd_ready,
    output ccpr_pkg::ccpr_rd_t rd_data
);
    import ccpr_pkg::*;

    // ------------------------------------------------------------------------
    // Declarations.
    // ------------------------------------------------------------------------
    localparam int SUM_W = LIN_W + $clog2(NCH + 1);
    localparam int PIN_W = NCH * (N_RANGE + ADC_W);
    localparam int PW = $clog2(PIPE_DEPTH);
    localparam int EV_W = NCH * LIN_W;

    // Three-stage pin synchroniser and agreement filter.
    logic [PIN_W-1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q;
    // Crossing cycle counter and crossing strobe.
    logic [$clog2(XING_CYC+1)-1:0] xcnt_q;
    logic tick;
    // Stage strobes after raw capture, lookup and summing.
    logic raw_v_q, lin_v_q, sum_v_q;
    // Per channel raw and linearised words.
    ccpr_raw_t raw_q [0:NCH-1];
    logic [EV_W-1:0] lin_all;
    // Tower sum.
    logic [SUM_W-1:0] sum_d, sum_q;
    // Energy to transverse energy table.
    logic [ET_W-1:0] et_mem [0:(1<<ET_AW)-1];
    // Delay ring of crossings.
    logic [EV_W-1:0] dly [0:PIPE_DEPTH-1];
    logic [PW-1:0] wptr_q;
    logic primed_q;
    logic [EV_W-1:0] oldest;
    // Second-level buffers.
    logic [EV_W-1:0] l2mem [0:L2_NBUF-1];
    logic [L2_NBUF-1:0] pend_q;
    // Lowest pending buffer, the next one to be read.
    logic [1:0] pend_id;
    logic [1:0] free_id;
    logic free_ok;
    // Readout sequencer.
    ccpr_rd_state_t rd_st_q;
    logic [1:0] rd_buf_q;
    logic [7:0] rd_ch_q;
    logic f_in_ready, f_in_valid;
    ccpr_rd_t f_in_data;

    // Lowest range whose capacitor is not saturated; the last one otherwise.
    function automatic logic [RANGE_W-1:0] pick_range(input logic [N_RANGE-1:0] hit);
        logic [RANGE_W-1:0] r;
        r = RANGE_W'(N_RANGE - 1);
        for (int i = N_RANGE - 1; i >= 0; i--) begin
            if (!hit[i]) begin
                r = RANGE_W'(i);
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------------------
    // Pin synchroniser.
    // ------------------------------------------------------------------------
    // A bit only changes once the second and third stages agree.
    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            pin_s3_q <= '0;
            pin_f_q <= '0;
        end else if (ce) begin
            pin_s1_q <= {cmp_hit_pin, adc_pin};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_f_q <= (~(pin_s2_q ^ pin_s3_q) & pin_s3_q) | ((pin_s2_q ^ pin_s3_q) & pin_f_q);
        end
    end

    // ------------------------------------------------------------------------
    // Crossing timer and bank rotation.
    // ------------------------------------------------------------------------
    assign tick = ce && (xcnt_q == ($bits(xcnt_q))'(XING_CYC - 1));

    always_ff @(posedge mclk) begin
        if (rst) begin
            xcnt_q <= '0;
        end else if (ce) begin
            xcnt_q <= tick ? '0 : xcnt_q + 1'b1;
        end
    end

    // Each bank walks integrate, compare, digitise, reset in turn.
    always_ff @(posedge mclk) begin
        if (rst) begin
            int_bank_q <= BANK_W'(0);
            cmp_bank_q <= BANK_W'(N_BANK - 1);
            mux_bank_q <= BANK_W'(N_BANK - 2);
            rst_bank_q <= BANK_W'(N_BANK - 3);
        end else if (tick) begin
            int_bank_q <= int_bank_q + 1'b1;
            cmp_bank_q <= int_bank_q;
            mux_bank_q <= cmp_bank_q;
            rst_bank_q <= mux_bank_q;
        end
    end

    // ------------------------------------------------------------------------
    // Per channel range choice, raw capture and linearisation.
    // ------------------------------------------------------------------------
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        // Lookup memory holding this channel's calibration.
        logic [LIN_W-1:0] lut [0:(1<<RAW_W)-1];
        logic [N_RANGE-1:0] hit;
        logic [ADC_W-1:0] adc;
        logic [LIN_W-1:0] lin_q;

        assign hit = pin_f_q[NCH*ADC_W + c*N_RANGE +: N_RANGE];
        assign adc = pin_f_q[c*ADC_W +: ADC_W];
        assign lin_all[c*LIN_W +: LIN_W] = lin_q;

        // Comparator decision latched at crossing end drives the mux next crossing.
        always_ff @(posedge mclk) begin
            if (rst) begin
                mux_range_q[c*RANGE_W +: RANGE_W] <= '0;
            end else if (tick) begin
                mux_range_q[c*RANGE_W +: RANGE_W] <= pick_range(hit);
            end
        end

        // Conversion of the digitised bank closes with the crossing.
        always_ff @(posedge mclk) begin
            if (rst) begin
                raw_q[c] <= '0;
            end else if (tick) begin
                raw_q[c].bank <= mux_bank_q;
                raw_q[c].range <= mux_range_q[c*RANGE_W +: RANGE_W];
                raw_q[c].mant <= adc;
            end
        end

        // Calibration writes and the per crossing lookup.
        always_ff @(posedge mclk) begin
            if (ce && cal_we && !cal_et && cal_ch == 8'(c)) begin
                lut[cal_addr] <= cal_data;
            end
            if (ce && raw_v_q) begin
                lin_q <= lut[raw_q[c]];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Stage strobes.
    // ------------------------------------------------------------------------
    // One strobe per crossing ripples down the digital pipeline.
    always_ff @(posedge mclk) begin
        if (rst) begin
            raw_v_q <= 1'b0;
            lin_v_q <= 1'b0;
            sum_v_q <= 1'b0;
        end else if (ce) begin
            raw_v_q <= tick;
            lin_v_q <= raw_v_q;
            sum_v_q <= lin_v_q;
        end
    end

    // ------------------------------------------------------------------------
    // Trigger tower sum and transverse energy.
    // ------------------------------------------------------------------------
    // tower sum of channels
    always_comb begin
        sum_d = '0;
        for (int i = 0; i < NCH; i++) begin
            sum_d = sum_d + SUM_W'(lin_all[i*LIN_W +: LIN_W]);
        end
    end

    // Sum register, loaded once per crossing.
    always_ff @(posedge mclk) begin
        if (rst) begin
            sum_q <= '0;
        end else if (ce && lin_v_q) begin
            sum_q <= sum_d;
        end
    end

    // Energy table load and lookup; the top sum bits address it.
    always_ff @(posedge mclk) begin
        if (ce && cal_we && cal_et) begin
            et_mem[cal_addr[ET_AW-1:0]] <= cal_data[ET_W-1:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            et_q <= '0;
            et_valid_q <= 1'b0;
        end else if (ce) begin
            et_valid_q <= sum_v_q;
            if (sum_v_q) begin
                et_q <= et_mem[sum_q[SUM_W-1 -: ET_AW]];
            end
        end
    end

    // ------------------------------------------------------------------------
    // First-level delay ring.
    // ------------------------------------------------------------------------
    // The slot about to be overwritten holds the crossing from PIPE_DEPTH ago.
    assign oldest = dly[wptr_q];

    always_ff @(posedge mclk) begin
        if (rst) begin
            wptr_q <= '0;
            primed_q <= 1'b0;
        end else if (ce && lin_v_q) begin
            if (wptr_q == PW'(PIPE_DEPTH - 1)) begin
                wptr_q <= '0;
                primed_q <= 1'b1;
            end else begin
                wptr_q <= wptr_q + 1'b1;
            end
        end
    end

    // Ring storage, never reset.
    always_ff @(posedge mclk) begin
        if (ce && lin_v_q) begin
            dly[wptr_q] <= lin_all;
        end
    end

    // ------------------------------------------------------------------------
    // Second-level buffers.
    // ------------------------------------------------------------------------
    // only empty buffers are free
    always_comb begin
        free_ok = 1'b0;
        free_id = 2'h0;
        for (int i = L2_NBUF - 1; i >= 0; i--) begin
            if (!l2_full_q[i]) begin
                free_ok = 1'b1;
                free_id = 2'(i);
            end
        end
    end

    // Buffer contents, written on a first-level accept.
    always_ff @(posedge mclk) begin
        if (ce && lin_v_q && primed_q && l1_accept && !l1_reject && free_ok) begin
            l2mem[free_id] <= oldest;
        end
    end

    // Occupancy, pending readout and overflow.
    always_ff @(posedge mclk) begin
        if (rst) begin
            l2_full_q <= '0;
            pend_q <= '0;
            l1_overflow_q <= 1'b0;
        end else if (ce) begin
            // A release arrives by second-level reject or by a finished read.
            if (l2_reject && !pend_q[l2_buf] && !(rd_st_q == RD_SEND && rd_buf_q == l2_buf)) begin
                l2_full_q[l2_buf] <= 1'b0;
            end
            if (rd_st_q == RD_SEND && f_in_ready && rd_ch_q == 8'(NCH - 1)) begin
                l2_full_q[rd_buf_q] <= 1'b0;
            end
            if (rd_st_q == RD_IDLE && pend_q != '0) begin
                pend_q[pend_id] <= 1'b0;
            end
            // Marking a buffer for readout wins over any clear.
            if (l2_accept && l2_full_q[l2_buf] && !(rd_st_q == RD_SEND && rd_buf_q == l2_buf)) begin
                pend_q[l2_buf] <= 1'b1;
            end
            // Filling a buffer wins over a clear in the same cycle.
            if (lin_v_q && primed_q && l1_accept && !l1_reject) begin
                if (free_ok) begin
                    l2_full_q[free_id] <= 1'b1;
                end else begin
                    l1_overflow_q <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Readout sequencer.
    // ------------------------------------------------------------------------
    assign f_in_valid = (rd_st_q == RD_SEND);

    // Pending buffers are served lowest index first, one at a time.
    always_comb begin
        pend_id = 2'h0;
        for (int i = L2_NBUF - 1; i >= 0; i--) begin
            if (pend_q[i]) begin
                pend_id = 2'(i);
            end
        end
    end

    // Word offered to the FIFO: one channel of the buffer being read.
    always_comb begin
        f_in_data.last = (rd_ch_q == 8'(NCH - 1));
        f_in_data.buf_id = rd_buf_q;
        f_in_data.data = l2mem[rd_buf_q][rd_ch_q*LIN_W +: LIN_W];
    end

    // Lowest pending buffer is read one channel per accepted push.
    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_st_q <= RD_IDLE;
            rd_buf_q <= 2'h0;
            rd_ch_q <= 8'h00;
        end else if (ce) begin
            unique case (rd_st_q)
                RD_IDLE: begin
                    // The buffer is chosen here, so an accept taken during a read still finds its own buffer.
                    rd_ch_q <= 8'h00;
                    if (pend_q != '0) begin
                        rd_buf_q <= pend_id;
                        rd_st_q <= RD_SEND;
                    end
                end
                RD_SEND: begin
                    if (f_in_ready) begin
                        if (rd_ch_q == 8'(NCH - 1)) begin
                            rd_st_q <= RD_IDLE;
                        end else begin
                            rd_ch_q <= rd_ch_q + 8'h01;
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Readout FIFO.
    // ------------------------------------------------------------------------
    ccpr_fifo #(
        .W($bits(ccpr_rd_t)),
        .DEPTH(FDEPTH)
    ) u_fifo (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .in_data(f_in_data),
        .out_valid(rd_valid),
        .out_ready(rd_ready),
        .out_data(rd_data)
    );

endmodule // ccpr_readout

`default_nettype wire

// ---- verif/ccpr_readout_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
// --------------------------------------------
// Port checker of the charge readout pipeline.
// --------------------------------------------
module ccpr_readout_checker
    import ccpr_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Stage banks.
    input wire logic [ccpr_pkg::BANK_W-1:0] int_bank_q,
    input wire logic [ccpr_pkg::BANK_W-1:0] cmp_bank_q,
    input wire logic [ccpr_pkg::BANK_W-1:0] mux_bank_q,
    input wire logic [ccpr_pkg::BANK_W-1:0] rst_bank_q,
    // Trigger and buffers.
    input wire logic et_valid_q,
    input wire logic l1_accept,
    input wire logic l1_overflow_q,
    input wire logic [ccpr_pkg::L2_NBUF-1:0] l2_full_q,
    // Readout stream.
    input wire logic rd_valid,
    input wire logic rd_ready,
    input wire ccpr_pkg::ccpr_rd_t rd_data
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Cycles since the last first-level accept, saturating.
    logic [3:0] quiet_q;
    always_ff @(posedge mclk) begin
        quiet_q <= (rst || l1_accept) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hF};
    end
    // A bank stays for one crossing, then steps.
    sequence s_hold;
        $stable(int_bank_q) [*2] ##1 $changed(int_bank_q);
    endsequence
    // Trigger words come once per crossing.
    sequence s_et_gap;
        !et_valid_q [*2] ##1 et_valid_q;
    endsequence
    property p_stage_order;
        cmp_bank_q == int_bank_q - 2'h1 && mux_bank_q == int_bank_q - 2'h2 && rst_bank_q == int_bank_q - 2'h3;
    endproperty
    property p_bank_step;
        $changed(int_bank_q) |-> int_bank_q == $past(int_bank_q) + 2'h1;
    endproperty
    property p_bank_cycle;
        $changed(int_bank_q) |=> s_hold;
    endproperty
    property p_et_pulse;
        et_valid_q |=> s_et_gap;
    endproperty
    property p_et_after_tick;
        $changed(int_bank_q) |-> ##3 et_valid_q;
    endproperty
    property p_overflow_sticky;
        l1_overflow_q |=> l1_overflow_q;
    endproperty
    property p_full_set;
        |(l2_full_q & ~$past(l2_full_q)) |-> quiet_q < 4'hC;
    endproperty
    property p_rd_hold;
        rd_valid && !rd_ready |=> rd_valid && $stable(rd_data);
    endproperty
    a_stage_order: assert property (p_stage_order) else $error("stage banks out of order");
    a_bank_step: assert property (p_bank_step) else $error("bank did not step by one");
    a_bank_cycle: assert property (p_bank_cycle) else $error("bank held wrong length");
    a_et_pulse: assert property (p_et_pulse) else $error("trigger word spacing wrong");
    a_et_after_tick: assert property (p_et_after_tick) else $error("trigger word late");
    a_overflow_sticky: assert property (p_overflow_sticky) else $error("overflow flag cleared");
    a_full_set: assert property (p_full_set) else $error("buffer filled without accept");
    a_rd_hold: assert property (p_rd_hold) else $error("readout word changed while stalled");
endmodule // ccpr_readout_checker
bind ccpr_readout ccpr_readout_checker chk_u (.mclk, .rst, .int_bank_q, .cmp_bank_q, .mux_bank_q, .rst_bank_q,
    .et_valid_q, .l1_accept, .l1_overflow_q, .l2_full_q, .rd_valid, .rd_ready, .rd_data);
`default_nettype wire

// ---- verif/ccpr_readout_sink.sv ----
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------
// Readout controller model that stalls at times.
// ----------------------------------------------
module ccpr_readout_sink (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Readout handshake.
    output var logic rd_ready
);
    // Pattern counter; ready drops two cycles in eight.
    logic [2:0] cnt = 3'h0;
    initial rd_ready = 1'b0;
    always @(negedge mclk) begin
        cnt <= rst ? 3'h0 : cnt + 3'h1;
        rd_ready <= !rst && cnt[2:1] != 2'h0;
    end
endmodule // ccpr_readout_sink
`default_nettype wire

// ---- verif/test_calorimeter_charge_pipeline_readout.sv ----
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------
// Self-checking bench of the readout path.
// ---------------------------------------
module test_calorimeter_charge_pipeline_readout;
    import ccpr_pkg::*;
    localparam int NCH = 4;
    logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, cal_we = 1'b0, cal_et = 1'b0;
    logic l1_accept = 1'b0, l1_reject = 1'b0, l2_accept = 1'b0, l2_reject = 1'b0, rd_valid, rd_ready;
    logic [1:0] l2_buf = 2'h0;
    logic [7:0] cal_ch = 8'h0;
    logic [RAW_W-1:0] cal_addr = '0;
    logic [LIN_W-1:0] cal_data = '0;
    logic [NCH*N_RANGE-1:0] cmp_hit_pin = '0;
    logic [NCH*ADC_W-1:0] adc_pin = '0;
    logic [L2_NBUF-1:0] l2_full_q;
    logic l1_overflow_q;
    logic [ET_W-1:0] et_q;
    logic [NCH*RANGE_W-1:0] mux_range_q;
    logic [18:0] tsum = '0;
    ccpr_rd_t rd_data;
    ccpr_rd_t exp_q [$];
    ccpr_lin_t val [NCH];
    logic [31:0] seed = 32'h7E10;
    int fail_count = 0, check_count = 0;
    // Clock of 50 ns.
    initial begin
        forever #25 mclk = ~mclk;
    end
    ccpr_readout #(.PIPE_DEPTH(4)) dut_u (.mclk, .rst, .ce, .cmp_hit_pin, .adc_pin, .int_bank_q(), .cmp_bank_q(),
        .mux_bank_q(), .rst_bank_q(), .mux_range_q, .cal_we, .cal_et, .cal_ch, .cal_addr, .cal_data, .et_q,
        .et_valid_q(), .l1_accept, .l1_reject, .l1_overflow_q, .l2_accept, .l2_reject, .l2_buf, .l2_full_q,
        .rd_valid, .rd_ready, .rd_data);
    ccpr_readout_sink sink_u (.mclk, .rst, .rd_ready);
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic check(input string what, input logic [18:0] exp, input logic [18:0] got);
        check_count++;
        if (exp !== got) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Holds one first-level decision for n whole crossings.
    task automatic decide(input logic acc, input int n);
        l1_accept = acc;
        l1_reject = !acc;
        cyc(3 * n);
        l1_accept = 1'b0;
        l1_reject = 1'b0;
    endtask
    task automatic conclude;
        if (fail_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Each accepted readout word is matched with the oldest expectation.
    always @(posedge mclk) begin
        if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
            check("rd_data", (exp_q.size() != 0) ? exp_q.pop_front() : 19'h7FFFF, rd_data);
        end
    end
    // Watchdog against a hang.
    initial begin
        cyc(3000);
        fail_count++;
        $display("unexpected watchdog expected done seen hang");
        conclude;
    end
    initial begin
        int n;
        cyc(10);
        rst = 1'b0;
        seed = xs(seed);
        adc_pin = {seed[7:0], seed};
        // Same value in all banks, so any bank tag reads alike.
        for (int c = 0; c < NCH; c++) begin
            seed = xs(seed);
            val[c] = seed[LIN_W-1:0];
            tsum += 19'(val[c]);
            for (int b = 0; b < N_BANK; b++) begin
                cal_we = 1'b1;
                cal_ch = 8'(c);
                cal_addr = {2'(b), 3'h0, adc_pin[c*ADC_W +: ADC_W]};
                cal_data = val[c];
                cyc(1);
            end
        end
        // One energy entry, at the top bits of the expected tower sum.
        cal_et = 1'b1;
        cal_addr = 15'(tsum[18:7]);
        cal_data = seed[31:16];
        cyc(1);
        cal_we = 1'b0;
        cyc(60);
        check("et_q", 19'(cal_data[ET_W-1:0]), 19'(et_q));
        decide(1'b0, 1);
        cyc(12);
        check("l2_full", 19'h0, 19'(l2_full_q));
        decide(1'b1, 5);
        cyc(12);
        check("l2_full", 19'hF, 19'(l2_full_q));
        check("l1_overflow", 19'h1, 19'(l1_overflow_q));
        l2_buf = 2'h3;
        l2_reject = 1'b1;
        cyc(1);
        l2_reject = 1'b0;
        cyc(3);
        check("l2_full", 19'h7, 19'(l2_full_q));
        // Back-to-back accepts of the held buffers, then a refused one for the buffer in read.
        l2_accept = 1'b1;
        for (int b = 0; b < 4; b++) begin
            for (int c = 0; c < NCH && b < 3; c++) exp_q.push_back({c == NCH - 1, 2'(b), val[c]});
            l2_buf = 2'(b % 3);
            cyc(1);
        end
        l2_accept = 1'b0;
        n = 0;
        while (l2_full_q !== 4'h0 && n < 100) begin
            cyc(1);
            n++;
        end
        cyc(60);
        // Random hits, channel 3 saturated: lowest free range, else the top one.
        seed = xs(seed);
        cmp_hit_pin = {8'hFF, seed[23:0]};
        cyc(12);
        for (int c = 0; c < NCH; c++) begin
            n = N_RANGE - 1;
            for (int r = N_RANGE - 1; r >= 0; r--) if (!cmp_hit_pin[c*N_RANGE + r]) n = r;
            check("mux_range", 19'(n), 19'(mux_range_q[c*RANGE_W +: RANGE_W]));
        end
        check("queue", 19'h0, 19'(exp_q.size()));
        check("l2_full", 19'h0, 19'(l2_full_q));
        conclude;
    end
endmodule // test_calorimeter_charge_pipeline_readout
`default_nettype wire
